/* File: hw/cpu_interrupt_priority_controller.sv */
// CPU interrupt priority controller: levels, arbitration, vector table and registers.
`include "intc_cfg.svh"
module cpu_interrupt_priority_controller
    import intc_pkg::*;
#(
    parameter int NVEC   = 64,
    parameter int PC_W   = 16
)(
    input  wire logic            i_sys_clk,
    input  wire logic            i_rstn,
    // Register port.
    input  wire logic [7:0]      i_addr,
    input  wire logic [7:0]      i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output logic [7:0]           o_rdata,
    // Requests from peripherals and core state.
    input  wire logic [NVEC-1:0] i_irq_req,
    input  wire logic            i_nmi_req,
    input  wire logic            i_global_ie,
    // Core handshake.
    output logic                 o_irq_valid,
    output logic [7:0]           o_irq_vector,
    output level_t               o_irq_level,
    input  wire logic            i_irq_ack,
    input  wire logic            i_interrupt_return,
    // Change protection.
    input  wire logic            i_key_write,
    input  wire logic            i_instr_done,
    // Memory layout.
    input  wire logic            i_boot_is_all,
    input  wire logic [PC_W-1:0] i_boot_end,
    output logic [PC_W-1:0]      o_vector_base,
    output logic [PC_W-1:0]      o_reset_pc
);

    // =====================================================================
    // Register state
    // =====================================================================

    logic       round_robin_enable_r;
    logic       round_robin_enable_nxt;
    logic       compact_table_enable_r;
    logic       compact_table_enable_nxt;
    logic       vector_base_select_r;
    logic       vector_base_select_nxt;
    logic [7:0] normal_priority_order_r;
    logic [7:0] normal_priority_order_nxt;
    logic [7:0] high_priority_vector_r;
    logic [7:0] high_priority_vector_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Executing-level flags.
    logic       nonmaskable_executing_r;
    logic       nonmaskable_executing_nxt;
    logic       high_level_executing_r;
    logic       high_level_executing_nxt;
    logic       normal_level_executing_r;
    logic       normal_level_executing_nxt;

    // Registered dispatch offer.
    logic       irq_valid_r;
    logic       irq_valid_nxt;
    logic [7:0] irq_vector_r;
    logic [7:0] irq_vector_nxt;
    logic [7:0] irq_raw_r;
    logic [7:0] irq_raw_nxt;
    level_t     irq_level_r;
    level_t     irq_level_nxt;

    // =====================================================================
    // Register decode
    // =====================================================================

    logic wr_control;
    logic wr_order;
    logic wr_high_vec;
    logic rd_control;
    logic rd_status;
    logic rd_order;
    logic rd_high_vec;
    logic unlocked;
    logic protected_write;

    assign wr_control  = i_wr && (i_addr == `INTC_OFS_CONTROL);
    assign wr_order    = i_wr && (i_addr == `INTC_OFS_ORDER);
    assign wr_high_vec = i_wr && (i_addr == `INTC_OFS_HIGH_VEC);
    assign rd_control  = i_rd && (i_addr == `INTC_OFS_CONTROL);
    assign rd_status   = i_rd && (i_addr == `INTC_OFS_STATUS);
    assign rd_order    = i_rd && (i_addr == `INTC_OFS_ORDER);
    assign rd_high_vec = i_rd && (i_addr == `INTC_OFS_HIGH_VEC);

    // A control write inside the window updates the guarded bits and ends the window.
    assign protected_write = wr_control && unlocked;

    intc_unlock_timer u_unlock (
        .i_sys_clk    (i_sys_clk),
        .i_rstn       (i_rstn),
        .i_key_write  (i_key_write),
        .i_instr_done (i_instr_done),
        .i_consume    (protected_write),
        .o_unlocked   (unlocked)
    );

    // =====================================================================
    // Control register
    // =====================================================================

    assign round_robin_enable_nxt = wr_control ? i_wdata[`INTC_BIT_ROUND_ROBIN]
                                               : round_robin_enable_r;  // [R5] [R18]
    assign compact_table_enable_nxt = protected_write ? i_wdata[`INTC_BIT_COMPACT]
                                                      : compact_table_enable_r;  // [R8] [R17]
    assign vector_base_select_nxt = protected_write ? i_wdata[`INTC_BIT_BASE_SEL]
                                                    : vector_base_select_r;  // [R18] [R17]

    // =====================================================================
    // Executing levels and dispatch
    // =====================================================================

    logic [NVEC-1:0] normal_req;
    logic            normal_found;
    logic [7:0]      normal_index;
    logic [7:0]      arb_start;
    logic            high_enabled;
    logic            high_pending;
    logic            take_nmi;
    logic            take_high;
    logic            take_normal;
    logic            ack_nmi;
    logic            ack_high;
    logic            ack_normal;
    logic            ret_nmi;
    logic            ret_high;
    logic            ret_normal;

    assign high_enabled = (high_priority_vector_r != `INTC_VEC_NONE);  // [R19]
    assign high_pending = high_enabled && (int'(high_priority_vector_r) < NVEC)
                          && i_irq_req[high_priority_vector_r[$clog2(NVEC)-1:0]];

    // Reset and non-maskable slots, and the promoted vector, never enter normal arbitration.
    generate
        for (genvar g = 0; g < NVEC; g++)
        begin : g_normal
            assign normal_req[g] = i_irq_req[g]
                && (8'(g) != `INTC_VEC_RESET) && (8'(g) != `INTC_VEC_NMI)  // [R2]
                && !(high_enabled && (8'(g) == high_priority_vector_r));  // [R23]
        end
    endgenerate

    // Fixed order searches from one past the order register value, so with it at zero the lowest number wins.
    assign arb_start = normal_priority_order_r;  // [R6]

    intc_rotate_arbiter #(
        .NVEC (NVEC)
    ) u_arbiter (
        .i_req   (normal_req),
        .i_last  (arb_start),
        .o_found (normal_found),
        .o_index (normal_index)
    );

    // The non-maskable level ignores the global enable and cannot itself be preempted.
    assign take_nmi    = i_nmi_req && !nonmaskable_executing_r;  // [R21] [R2]
    assign take_high   = !take_nmi && i_global_ie && high_pending
                         && !nonmaskable_executing_r && !high_level_executing_r;  // [R20] [R22]
    assign take_normal = !take_nmi && !take_high && i_global_ie && normal_found
                         && !nonmaskable_executing_r && !high_level_executing_r
                         && !normal_level_executing_r;  // [R22]

    // The offer is withdrawn for a cycle after an acknowledge while the flags settle.
    assign irq_valid_nxt = (take_nmi || take_high || take_normal) && !i_irq_ack;

    assign irq_level_nxt = take_nmi  ? lvl_nmi :
                           take_high ? lvl_high :
                           take_normal ? lvl_normal : lvl_none;

    assign irq_raw_nxt = take_nmi  ? `INTC_VEC_NMI :
                         take_high ? high_priority_vector_r :
                         take_normal ? normal_index : `INTC_VEC_NONE;

    // The compact table folds each level onto a single slot of its own.
    assign irq_vector_nxt = !compact_table_enable_r ? irq_raw_nxt :
                            take_nmi  ? `INTC_CVT_NMI :
                            take_high ? `INTC_CVT_HIGH :
                            take_normal ? `INTC_CVT_NORMAL : `INTC_VEC_NONE;  // [R7]

    assign ack_nmi    = i_irq_ack && irq_valid_r && (irq_level_r == lvl_nmi);
    assign ack_high   = i_irq_ack && irq_valid_r && (irq_level_r == lvl_high);
    assign ack_normal = i_irq_ack && irq_valid_r && (irq_level_r == lvl_normal);

    // A return ends the innermost running level only, exposing the one beneath.
    assign ret_nmi    = i_interrupt_return && nonmaskable_executing_r;  // [R15]
    assign ret_high   = i_interrupt_return && !nonmaskable_executing_r
                        && high_level_executing_r;  // [R15]
    assign ret_normal = i_interrupt_return && !nonmaskable_executing_r
                        && !high_level_executing_r && normal_level_executing_r;  // [R15]

    // A new entry in the same cycle as a return wins over the clear.
    assign nonmaskable_executing_nxt = ack_nmi
                                       || (nonmaskable_executing_r && !ret_nmi);  // [R12]
    assign high_level_executing_nxt = ack_high
                                      || (high_level_executing_r && !ret_high);  // [R13]
    assign normal_level_executing_nxt = ack_normal
                                        || (normal_level_executing_r && !ret_normal);  // [R14]

    // Hardware recording of the acknowledged vector wins over a software write.
    assign normal_priority_order_nxt = (ack_normal && round_robin_enable_r) ? irq_raw_r :
                                       wr_order ? i_wdata :
                                       normal_priority_order_r;  // [R3] [R4]

    assign high_priority_vector_nxt = wr_high_vec ? i_wdata : high_priority_vector_r;

    // =====================================================================
    // Read path
    // =====================================================================

    logic [7:0] control_view;
    logic [7:0] status_view;

    always_comb
    begin
        control_view = `INTC_RST_BYTE;
        control_view[`INTC_BIT_ROUND_ROBIN] = round_robin_enable_r;
        control_view[`INTC_BIT_COMPACT] = compact_table_enable_r;
        control_view[`INTC_BIT_BASE_SEL] = vector_base_select_r;
    end

    always_comb
    begin
        status_view = `INTC_RST_BYTE;
        status_view[`INTC_BIT_NMI_EX] = nonmaskable_executing_r;  // [R12]
        status_view[`INTC_BIT_HIGH_EX] = high_level_executing_r;  // [R13]
        status_view[`INTC_BIT_NORMAL_EX] = normal_level_executing_r;  // [R14]
    end

    assign rdata_nxt = rd_control  ? control_view :
                       rd_status   ? status_view :
                       rd_order    ? normal_priority_order_r :
                       rd_high_vec ? high_priority_vector_r : `INTC_RST_BYTE;

    // =====================================================================
    // State registers
    // =====================================================================

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            round_robin_enable_r    <= 1'b0;
            compact_table_enable_r  <= 1'b0;
            vector_base_select_r    <= 1'b0;
            normal_priority_order_r <= `INTC_RST_BYTE;
            high_priority_vector_r  <= `INTC_RST_BYTE;
            rdata_r                 <= `INTC_RST_BYTE;
        end
        else
        begin
            round_robin_enable_r    <= round_robin_enable_nxt;
            compact_table_enable_r  <= compact_table_enable_nxt;
            vector_base_select_r    <= vector_base_select_nxt;
            normal_priority_order_r <= normal_priority_order_nxt;
            high_priority_vector_r  <= high_priority_vector_nxt;
            rdata_r                 <= rdata_nxt;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            nonmaskable_executing_r  <= 1'b0;
            high_level_executing_r   <= 1'b0;
            normal_level_executing_r <= 1'b0;
        end
        else
        begin
            nonmaskable_executing_r  <= nonmaskable_executing_nxt;
            high_level_executing_r   <= high_level_executing_nxt;
            normal_level_executing_r <= normal_level_executing_nxt;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            irq_valid_r  <= 1'b0;
            irq_vector_r <= `INTC_VEC_NONE;
            irq_raw_r    <= `INTC_VEC_NONE;
            irq_level_r  <= lvl_none;
        end
        else
        begin
            irq_valid_r  <= irq_valid_nxt;
            irq_vector_r <= irq_vector_nxt;
            irq_raw_r    <= irq_raw_nxt;
            irq_level_r  <= irq_level_nxt;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================

    assign o_rdata      = rdata_r;
    assign o_irq_valid  = irq_valid_r;
    assign o_irq_vector = irq_vector_r;
    assign o_irq_level  = irq_level_r;

    // With the whole memory as boot section the table sits at its start.
    assign o_vector_base = (vector_base_select_r || i_boot_is_all)
                           ? `INTC_RESET_PC : i_boot_end;  // [R9] [R10]

    // The reset entry never moves with the table.
    assign o_reset_pc = `INTC_RESET_PC;  // [R11]

endmodule

/* File: hw/intc_cfg.svh */
// Constants for the CPU interrupt priority controller.
//
// Notes on behaviour
// [R1] Order value Y in static mode ranks vector Y+1 highest, Y lowest, wrapping around.
// [R2] Reset and non-maskable vectors always outrank every normal request.
// [R3] Round robin writes each acknowledged normal vector into the order register itself.
// [R4] Round robin puts the last acknowledged normal vector lowest for the next pick.
// [R5] Control bit 0 set selects round robin for normal arbitration.
// [R6] Control bit 0 clear gives fixed order where the lowest vector number wins; the code does so only with the order register at zero.
// [R7] Compact table maps non-maskable to 1, high to 2, all normal to 3.
// [R8] Control bit 5 enables the compact table when one, disables it when zero.
// [R9] Control bit 6 places vectors after boot section when zero, at its start when one.
// [R10] Vector base select is ignored when all program memory is boot section.
// [R11] System reset always starts the program counter at zero.
// [R12] Status bit 7 is set while a non-maskable handler runs, cleared by its return.
// [R13] Status bit 1 is set while a high handler runs or is preempted; cleared by its return.
// [R14] Status bit 0 is set while a normal handler runs or is preempted; cleared by its return.
// [R15] Each interrupt return restores the level held before that interrupt was entered.
// [R16] Software writes the key, then the protected bits within four instructions.
// [R17] Protected bits written without a valid unlock stay unchanged.
// [R18] Only base select and compact bits need the unlock; round robin is free.
// [R19] High vector register names the promoted vector; zero disables the high level.
// [R20] A high request preempts a normal handler, which resumes after the high return.
// [R21] Nothing preempts a non-maskable handler; it ignores the global enable.
// [R22] Maskable requests are dispatched only while the global enable is one.
// [R23] The promoted vector takes no part in normal arbitration.
`ifndef INTC_CFG_SVH
`define INTC_CFG_SVH

`define INTC_OFS_CONTROL      8'h00
`define INTC_OFS_STATUS       8'h01
`define INTC_OFS_ORDER        8'h02
`define INTC_OFS_HIGH_VEC     8'h03

`define INTC_BIT_ROUND_ROBIN  0
`define INTC_BIT_COMPACT      5
`define INTC_BIT_BASE_SEL     6
`define INTC_BIT_NORMAL_EX    0
`define INTC_BIT_HIGH_EX      1
`define INTC_BIT_NMI_EX       7

`define INTC_RST_BYTE         8'h00
`define INTC_VEC_NONE         8'h00
`define INTC_VEC_RESET        8'h00
`define INTC_VEC_NMI          8'h01
`define INTC_CVT_NMI          8'h01
`define INTC_CVT_HIGH         8'h02
`define INTC_CVT_NORMAL       8'h03
`define INTC_RESET_PC         16'h0000
`define INTC_UNLOCK_INSTR     3'h4

`endif

/* File: hw/intc_pkg.sv */
// Types shared by the CPU interrupt priority controller files.
package intc_pkg;

    typedef enum logic [1:0] {
        lvl_none,
        lvl_normal,
        lvl_high,
        lvl_nmi
    } level_t;

endpackage

/* File: hw/intc_rotate_arbiter.sv */
// Rotating first-pending search over the normal request lines.
module intc_rotate_arbiter
    import intc_pkg::*;
#(
    parameter int NVEC = 64
)(
    input  wire logic [NVEC-1:0] i_req,
    input  wire logic [7:0]      i_last,
    output logic                 o_found,
    output logic [7:0]           o_index
);

    // The search starts one past the stored vector and wraps, so the stored one is last.
    always_comb
    begin
        int k;
        int idx;
        k = 0;
        idx = 0;
        o_found = 1'b0;
        o_index = 8'h00;
        for (k = NVEC; k >= 1; k--)
        begin
            idx = (int'(i_last) + k) % NVEC;  // [R1] [R4]
            if (i_req[idx])
            begin
                o_found = 1'b1;
                o_index = 8'(idx);
            end
        end
    end

endmodule

/* File: hw/intc_unlock_timer.sv */
// Instruction-counted unlock window for the protected control bits.
`include "intc_cfg.svh"
module intc_unlock_timer
    import intc_pkg::*;
(
    input  wire logic i_sys_clk,
    input  wire logic i_rstn,
    input  wire logic i_key_write,
    input  wire logic i_instr_done,
    input  wire logic i_consume,
    output logic      o_unlocked
);

    logic [2:0] left_r;
    logic [2:0] left_nxt;

    // A fresh key restarts the window; a protected write or the count running out closes it.
    assign left_nxt = i_key_write ? `INTC_UNLOCK_INSTR :
                      i_consume ? 3'h0 :
                      (i_instr_done && left_r != 3'h0) ? left_r - 3'h1 : left_r;  // [R16]

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            left_r <= 3'h0;
        else
            left_r <= left_nxt;
    end

    assign o_unlocked = (left_r != 3'h0);  // [R17]

endmodule

/* File: tb/cpu_core_model.sv */
// CPU core model that acknowledges offers after a set delay.
module cpu_core_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_enable,
    input  wire logic [3:0] i_delay,
    input  wire logic       i_irq_valid,
    output logic            o_irq_ack
);
    logic [3:0] wait_r;

    // ====================
    // Offer acceptance
    // Ack once per offer, counting only while enabled.
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wait_r    <= 4'h0;
            o_irq_ack <= 1'b0;
        end
        else
        begin
            o_irq_ack <= 1'b0;
            if (!i_irq_valid || !i_enable || o_irq_ack)
                wait_r <= 4'h0;
            else if (wait_r == i_delay)
                o_irq_ack <= 1'b1;
            else if (wait_r != 4'hf)
                wait_r <= wait_r + 4'h1;
        end
    end
endmodule

/* File: tb/cpu_interrupt_priority_controller_tb.sv */
// Self-checking bench for the CPU interrupt priority controller.
module cpu_interrupt_priority_controller_tb
    import intc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_sys_clk, i_rstn, i_wr, i_rd, i_nmi_req, i_global_ie, irq_ack, en;
    logic        i_interrupt_return, i_key_write, i_instr_done, i_boot_is_all, o_irq_valid;
    logic [7:0]  i_addr, i_wdata, o_rdata, o_irq_vector;
    logic [15:0] i_irq_req, i_boot_end, o_vector_base, o_reset_pc;
    logic [3:0]  dly;
    level_t      o_irq_level;
    int          errors, n_compared, cycles;
    logic [7:0]  ord [4] = '{8'h00, 8'h03, 8'h07, 8'h0c};
    logic [7:0]  seq [4] = '{8'h03, 8'h07, 8'h0c, 8'h03};

    cpu_interrupt_priority_controller #(.NVEC(16), .PC_W(16)) cpu_interrupt_priority_controller_inst (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_req(i_irq_req),
        .i_nmi_req(i_nmi_req), .i_global_ie(i_global_ie), .o_irq_valid(o_irq_valid),
        .o_irq_vector(o_irq_vector), .o_irq_level(o_irq_level), .i_irq_ack(irq_ack),
        .i_interrupt_return(i_interrupt_return), .i_key_write(i_key_write),
        .i_instr_done(i_instr_done), .i_boot_is_all(i_boot_is_all),
        .i_boot_end(i_boot_end), .o_vector_base(o_vector_base), .o_reset_pc(o_reset_pc));

    cpu_core_model cpu_core_model_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
        .i_enable(en), .i_delay(dly), .i_irq_valid(o_irq_valid), .o_irq_ack(irq_ack));

    // ====================
    // Clock, timeout and verdict
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ====================
    // Access tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk(what, o_rdata, exp);
        @(posedge i_sys_clk);
    endtask

    // 0: key write, 1: interrupt return, else instruction done.
    task automatic pulse(input int k);
        case (k)
            0: i_key_write <= 1'b1;
            1: i_interrupt_return <= 1'b1;
            default: i_instr_done <= 1'b1;
        endcase
        @(posedge i_sys_clk);
        {i_key_write, i_interrupt_return, i_instr_done} <= 3'b000;
        @(posedge i_sys_clk);
    endtask

    task automatic take(input logic [7:0] v, input level_t l);
        int n = 0;
        en <= 1'b1;
        do
        begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        while (irq_ack !== 1'b1 && n < 60);
        chk("core ack", irq_ack, 16'h0001);
        chk("offer vector", o_irq_vector, v);
        chk("offer level", o_irq_level, l);
        @(posedge i_sys_clk);
        en <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    task automatic idle_chk();
        repeat (8)
        begin
            @(posedge i_sys_clk);
            #1;
            chk("no offer", o_irq_valid, 16'h0000);
        end
        @(posedge i_sys_clk);
    endtask

    // ====================
    // Scenarios
    initial
    begin
        {i_rstn, i_wr, i_rd, i_nmi_req, i_global_ie, en} = 6'h00;
        {i_interrupt_return, i_key_write, i_instr_done, i_boot_is_all} = 4'h0;
        {i_addr, i_wdata, dly, i_irq_req} = '0;
        i_boot_end = 16'h0200;
        repeat (20) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        @(posedge i_sys_clk);
        for (int a = 0; a < 5; a++)
            rd_chk("reset value", a[7:0], 8'h00);
        chk("reset pc", o_reset_pc, 16'h0000);
        chk("vector base", o_vector_base, 16'h0200);
        wr(8'h01, 8'hff);
        rd_chk("status read only", 8'h01, 8'h00);
        wr(8'h00, 8'h61);
        rd_chk("locked control", 8'h00, 8'h01);
        pulse(0);
        wr(8'h00, 8'h60);
        rd_chk("unlocked control", 8'h00, 8'h60);
        chk("vector base", o_vector_base, 16'h0000);
        pulse(0);
        repeat (4) pulse(2);
        wr(8'h00, 8'h00);
        rd_chk("expired window", 8'h00, 8'h60);
        i_global_ie <= 1'b1;
        i_irq_req <= 16'h0020;
        take(8'h03, lvl_normal);
        i_irq_req <= 16'h0000;
        pulse(1);
        i_nmi_req <= 1'b1;
        take(8'h01, lvl_nmi);
        i_nmi_req <= 1'b0;
        pulse(1);
        wr(8'h03, 8'h06);
        i_irq_req <= 16'h0040;
        take(8'h02, lvl_high);
        i_irq_req <= 16'h0000;
        pulse(1);
        pulse(0);
        wr(8'h00, 8'h00);
        rd_chk("control cleared", 8'h00, 8'h00);
        chk("vector base", o_vector_base, 16'h0200);
        i_boot_is_all <= 1'b1;
        @(posedge i_sys_clk);
        #1;
        chk("boot all base", o_vector_base, 16'h0000);
        @(posedge i_sys_clk);
        i_boot_is_all <= 1'b0;
        wr(8'h03, 8'h00);
        // Pass 0: order by hand; pass 1: round robin.
        i_irq_req <= 16'h1088;
        for (int m = 0; m < 2; m++)
        begin
            dly <= m[0] ? 4'h5 : 4'h0;
            wr(8'h00, {7'h00, m[0]});
            wr(8'h02, 8'h00);
            for (int k = 0; k < 4; k++)
            begin
                if (m == 0)
                    wr(8'h02, ord[k]);
                take(seq[k], lvl_normal);
                rd_chk("order", 8'h02, m[0] ? seq[k] : ord[k]);
                pulse(1);
            end
        end
        wr(8'h00, 8'h00);
        wr(8'h03, 8'h09);
        i_irq_req <= 16'h0008;
        take(8'h03, lvl_normal);
        i_irq_req <= 16'h0208;
        take(8'h09, lvl_high);
        rd_chk("status", 8'h01, 8'h03);
        i_nmi_req <= 1'b1;
        take(8'h01, lvl_nmi);
        rd_chk("status", 8'h01, 8'h83);
        i_irq_req <= 16'h0228;
        idle_chk();
        i_nmi_req <= 1'b0;
        pulse(1);
        rd_chk("status", 8'h01, 8'h03);
        pulse(1);
        rd_chk("status", 8'h01, 8'h01);
        i_irq_req <= 16'h0000;
        pulse(1);
        rd_chk("status", 8'h01, 8'h00);
        wr(8'h03, 8'h00);
        i_irq_req <= 16'h0200;
        take(8'h09, lvl_normal);
        pulse(1);
        i_global_ie <= 1'b0;
        idle_chk();
        i_nmi_req <= 1'b1;
        take(8'h01, lvl_nmi);
        {i_nmi_req, i_irq_req} <= 17'h00000;
        pulse(1);
        report_and_stop();
    end
endmodule

/* File: tb/intc_port_chk.sv */
// Port assertions for the interrupt priority controller.
module intc_port_chk
    import intc_pkg::*;
#(
    parameter int PC_W = 16
)(
    input wire logic            i_sys_clk,
    input wire logic            i_rstn,
    input wire logic [7:0]      i_addr,
    input wire logic            i_rd,
    input wire logic [7:0]      o_rdata,
    input wire logic            i_nmi_req,
    input wire logic            i_global_ie,
    input wire logic            o_irq_valid,
    input wire logic [7:0]      o_irq_vector,
    input wire level_t          o_irq_level,
    input wire logic            i_irq_ack,
    input wire logic            i_boot_is_all,
    input wire logic [PC_W-1:0] o_vector_base,
    input wire logic [PC_W-1:0] o_reset_pc
);
    // ====================
    // Assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    a_reset_pc_zero: assert property (o_reset_pc == 16'h0000)
        else $error("reset pc nonzero");
    a_boot_all_base: assert property (i_boot_is_all |-> o_vector_base == 16'h0000)
        else $error("boot-all base nonzero");
    a_ctrl_spare_zero: assert property ($past(i_rd) && $past(i_addr) == 8'h00
        |-> o_rdata[7] == 1'b0 && o_rdata[4:1] == 4'h0)
        else $error("control spare bits set");
    a_status_spare_zero: assert property ($past(i_rd) && $past(i_addr) == 8'h01
        |-> o_rdata[6:2] == 5'h00)
        else $error("status spare bits set");
    a_nmi_vector_one: assert property (o_irq_valid && o_irq_level == lvl_nmi
        |-> o_irq_vector == 8'h01)
        else $error("nmi offer vector wrong");
    a_normal_above_one: assert property (o_irq_valid && o_irq_level == lvl_normal
        |-> o_irq_vector > 8'h01 && !$past(i_nmi_req))
        else $error("normal offer beside nmi");
    a_maskable_needs_ie: assert property (o_irq_valid && o_irq_level inside
        {lvl_normal, lvl_high} |-> $past(i_global_ie))
        else $error("maskable offer with ie low");
    a_nmi_not_preempted: assert property (o_irq_valid && o_irq_level == lvl_nmi
        && i_irq_ack |=> !o_irq_valid [*2])
        else $error("offer during nmi handler");
    a_high_vec_nonzero: assert property (o_irq_valid && o_irq_level == lvl_high
        |-> o_irq_vector != 8'h00)
        else $error("high offer vector zero");
endmodule

bind cpu_interrupt_priority_controller intc_port_chk #(.PC_W(PC_W)) intc_port_chk_inst (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_nmi_req(i_nmi_req), .i_global_ie(i_global_ie),
    .o_irq_valid(o_irq_valid), .o_irq_vector(o_irq_vector), .o_irq_level(o_irq_level),
    .i_irq_ack(i_irq_ack), .i_boot_is_all(i_boot_is_all),
    .o_vector_base(o_vector_base), .o_reset_pc(o_reset_pc));
